// file: hw/host_command_decoder.sv
`timescale 1ns/1ps

// Decodes host command bytes into the setup actions of this block.
module host_command_decoder
    import sleep_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Command port byte stream
    input wire host_byte_t i_cmd,
    // Decoded actions
    output logic o_timeout_wr,
    output logic o_outctl_wr,
    output logic o_outctl_rd,
    output logic [7:0] o_data,
    output logic o_cmd_done
);

    typedef enum logic [1:0] {
        DEC_IDLE = 2'b00,
        DEC_TIMEOUT = 2'b01,
        DEC_OUTCTL = 2'b11
    } dec_state_t;

    dec_state_t state;
    logic unlocked;

    wire logic take = i_cmd.valid;
    wire logic is_unlock = take && state == DEC_IDLE &&
                           i_cmd.data == CMD_UNLOCK;
    wire logic is_lock = take && state == DEC_IDLE &&
                         i_cmd.data == CMD_LOCK;
    wire logic is_timeout_cmd = take && state == DEC_IDLE && unlocked &&
                                i_cmd.data == CMD_SET_TIMEOUT;
    wire logic is_outctl_cmd = take && state == DEC_IDLE &&
                               i_cmd.data == CMD_WRITE_OUTCTL;
    wire logic is_read_cmd = take && state == DEC_IDLE &&
                             i_cmd.data == CMD_READ_OUTCTL;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= DEC_IDLE;
            unlocked <= 1'b0;
            o_timeout_wr <= 1'b0;
            o_outctl_wr <= 1'b0;
            o_outctl_rd <= 1'b0;
            o_data <= 8'h00;
            o_cmd_done <= 1'b0;
        end else begin
            o_timeout_wr <= take && state == DEC_TIMEOUT;
            o_outctl_wr <= take && state == DEC_OUTCTL;
            o_outctl_rd <= is_read_cmd;
            o_cmd_done <= take && !is_timeout_cmd && !is_outctl_cmd;
            if (take) begin
                o_data <= i_cmd.data;
            end
            if (is_unlock) begin
                unlocked <= 1'b1;
            end else if (is_lock) begin
                unlocked <= 1'b0;
            end
            unique case (state)
                DEC_IDLE: begin
                    if (is_timeout_cmd) begin
                        state <= DEC_TIMEOUT;
                    end else if (is_outctl_cmd) begin
                        state <= DEC_OUTCTL;
                    end
                end
                DEC_TIMEOUT, DEC_OUTCTL: begin
                    if (take) begin
                        state <= DEC_IDLE;
                    end
                end
                default: state <= DEC_IDLE;
            endcase
        end
    end

endmodule

// file: hw/self_timed_power.sv
`timescale 1ns/1ps

module self_timed_power
    import sleep_pkg::*;
#(
    parameter longint unsigned IDLE_CYCLES = IDLE_TICK_CYCLES,
    parameter longint unsigned DELAY_CYCLES = DELAY_TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_soft_reset,
    // Host command and data ports
    input wire host_byte_t i_cmd,
    output logic [7:0] o_read_data,
    output logic o_read_valid,
    // Power-control port and host activity
    input wire logic [7:0] i_power_ctl,
    input wire logic i_wake_access,
    input wire logic i_busy,
    // Power state and activity flags
    output power_state_t o_power_state,
    output logic o_activity_owned,
    // General-purpose outputs
    output logic o_aux_output_zero,
    output logic o_aux_output_one
);

    initial begin
        if (IDLE_CYCLES < 2 || DELAY_CYCLES < 2) begin
            $error("self_timed_power: tick periods too short");
        end
    end

    // ----------------------------------------------------------------
    // Command decoding
    // ----------------------------------------------------------------
    logic timeout_wr;
    logic outctl_wr;
    logic outctl_rd;
    logic cmd_done;
    logic [7:0] cmd_data;

    host_command_decoder u_decoder (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_cmd(i_cmd),
        .o_timeout_wr(timeout_wr),
        .o_outctl_wr(outctl_wr),
        .o_outctl_rd(outctl_rd),
        .o_data(cmd_data),
        .o_cmd_done(cmd_done)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    outctl_t outctl;
    logic [7:0] timeout;

    // Soft reset clears the timeout but leaves the output control register.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            outctl <= outctl_t'(OUTCTL_RESET);
            timeout <= 8'h00;
            o_read_data <= 8'h00;
            o_read_valid <= 1'b0;
        end else begin
            if (outctl_wr) begin
                outctl <= outctl_t'(cmd_data);
            end
            if (i_soft_reset) begin
                timeout <= 8'h00;
            end else if (timeout_wr) begin
                timeout <= cmd_data;
            end
            o_read_valid <= outctl_rd;
            if (outctl_rd) begin
                o_read_data <= outctl;
            end
        end
    end

    // ----------------------------------------------------------------
    // Idle timer
    // ----------------------------------------------------------------
    wire logic self_timed_on = (timeout != 8'h00);
    logic ctl_sync1;
    logic ctl_sync2;
    logic ctl_sync3;
    logic [7:0] ctl_q;
    logic [7:0] idle_count;
    logic op_open;
    logic idle_tick;

    // A command byte restarts the idle period; busy restarts it too.
    wire logic restart_idle = i_cmd.valid || cmd_done || i_wake_access ||
                              !self_timed_on;
    tick_divider #(
        .PERIOD(32'(IDLE_CYCLES)),
        .W(32)
    ) u_idle_div (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_restart(restart_idle || op_open),
        .o_tick(idle_tick)
    );

    wire logic idle_expired = self_timed_on && !op_open &&
                              idle_tick &&
                              idle_count == timeout - 8'h01;

    // ----------------------------------------------------------------
    // Power-control port edge detection
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl_sync1 <= 1'b0;
            ctl_sync2 <= 1'b0;
            ctl_sync3 <= 1'b0;
            ctl_q <= 8'h00;
        end else begin
            ctl_sync1 <= i_power_ctl[PWR_REQ_BIT];
            ctl_sync2 <= ctl_sync1;
            ctl_sync3 <= ctl_sync2;
            ctl_q <= i_power_ctl;
        end
    end

    wire logic req_rise = ctl_sync2 && ctl_sync3 == 1'b0 &&
                          ctl_sync2 == 1'b1;
    wire logic want_down = req_rise || idle_expired;
    wire power_state_t down_state = ctl_q[PWR_PARTIAL_BIT] ?
                                    PWR_PARTIAL : PWR_FULL;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            idle_count <= 8'h00;
            op_open <= 1'b0;
        end else begin
            // Timing waits until the current operation finishes.
            op_open <= i_busy;
            if (restart_idle || op_open || want_down) begin
                idle_count <= 8'h00;
            end else if (idle_tick) begin
                idle_count <= idle_count + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Power state
    // ----------------------------------------------------------------
    wire logic wake = i_wake_access || i_soft_reset;
    power_state_t next_power_state;

    assign next_power_state = (o_power_state != PWR_ON && wake) ? PWR_ON :
                              (o_power_state == PWR_ON && want_down) ?
                              down_state : o_power_state;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_power_state <= PWR_ON;
            o_activity_owned <= 1'b0;
        end else begin
            o_power_state <= next_power_state;
            o_activity_owned <= self_timed_on;
        end
    end

    // ----------------------------------------------------------------
    // Return delay after wake from full power-down
    // ----------------------------------------------------------------
    wire logic leave_full = o_power_state == PWR_FULL &&
                            next_power_state != PWR_FULL;
    logic delaying;
    logic [OUTCTL_DELAY_W-1:0] delay_count;
    logic delay_tick;

    tick_divider #(
        .PERIOD(32'(DELAY_CYCLES)),
        .W(32)
    ) u_delay_div (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_restart(leave_full),
        .o_tick(delay_tick)
    );

    wire logic delay_done = delay_count == outctl.delay;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            delaying <= 1'b0;
            delay_count <= '0;
        end else if (leave_full) begin
            delaying <= 1'b1;
            delay_count <= '0;
        end else if (delaying && delay_done) begin
            delaying <= 1'b0;
        end else if (delaying && delay_tick) begin
            delay_count <= delay_count + OUTCTL_DELAY_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // General-purpose outputs
    // ----------------------------------------------------------------
    wire logic in_full = o_power_state == PWR_FULL;
    wire logic normal0 = ctl_q[PWR_OUT0_BIT];
    wire logic normal1 = ctl_q[PWR_OUT1_BIT];
    wire logic hold0 = outctl.inv0 &&
                       (in_full || (delaying && outctl.dly0));
    wire logic hold1 = outctl.inv1 &&
                       (in_full || (delaying && outctl.dly1));

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_aux_output_zero <= 1'b0;
            o_aux_output_one <= 1'b0;
        end else begin
            o_aux_output_zero <= normal0 ^ hold0;
            o_aux_output_one <= normal1 ^ hold1;
        end
    end

endmodule

// file: hw/sleep_pkg.sv
package sleep_pkg;

    // ----------------------------------------------------------------
    // Host commands
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_UNLOCK = 8'hc6;
    localparam logic [7:0] CMD_SET_TIMEOUT = 8'hbd;
    localparam logic [7:0] CMD_LOCK = 8'hc7;
    localparam logic [7:0] CMD_WRITE_OUTCTL = 8'hcf;
    localparam logic [7:0] CMD_READ_OUTCTL = 8'hce;

    // ----------------------------------------------------------------
    // Power-control port fields
    // ----------------------------------------------------------------
    localparam int PWR_OUT0_BIT = 0;
    localparam int PWR_OUT1_BIT = 1;
    localparam int PWR_REQ_BIT = 2;
    localparam int PWR_PARTIAL_BIT = 3;

    // ----------------------------------------------------------------
    // Output power-down control register
    // ----------------------------------------------------------------
    localparam logic [7:0] OUTCTL_RESET = 8'h00;
    localparam int OUTCTL_DELAY_LSB = 0;
    localparam int OUTCTL_DELAY_W = 3;
    localparam int OUTCTL_RESERVED_BIT = 3;
    localparam int OUTCTL_INV0_BIT = 4;
    localparam int OUTCTL_DLY0_BIT = 5;
    localparam int OUTCTL_INV1_BIT = 6;
    localparam int OUTCTL_DLY1_BIT = 7;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint CLOCK_HZ = 10000000;
    localparam longint DELAY_TICK_HZ = 16;
    localparam longint IDLE_TICK_S = 8;
    localparam longint DELAY_TICK_CYCLES = CLOCK_HZ / DELAY_TICK_HZ;
    localparam longint IDLE_TICK_CYCLES = IDLE_TICK_S * CLOCK_HZ;

    typedef enum logic [1:0] {
        PWR_ON = 2'b00,
        PWR_PARTIAL = 2'b01,
        PWR_FULL = 2'b11
    } power_state_t;

    typedef struct packed {
        logic dly1;
        logic inv1;
        logic dly0;
        logic inv0;
        logic reserved;
        logic [2:0] delay;
    } outctl_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } host_byte_t;

endpackage

// file: hw/tick_divider.sv
`timescale 1ns/1ps

// Free-running divider giving a one-cycle enable every PERIOD cycles.
module tick_divider
    import sleep_pkg::*;
#(
    parameter int unsigned PERIOD = 16,
    parameter int W = 32
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Control
    input wire logic i_restart,
    // Tick
    output logic o_tick
);

    initial begin
        if (PERIOD < 2 || longint'(PERIOD) >= (64'd1 << W)) begin
            $error("tick_divider: PERIOD does not fit");
        end
    end

    logic [W-1:0] count;
    wire logic at_end = (count == W'(PERIOD - 1));

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count <= '0;
            o_tick <= 1'b0;
        end else if (i_restart) begin
            count <= '0;
            o_tick <= 1'b0;
        end else begin
            count <= at_end ? '0 : count + W'(1);
            o_tick <= at_end;
        end
    end

endmodule

// file: testbench/host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host software driving the command and power-control ports
// ----------------------------------------------------------------
module host_model
    import sleep_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_read_valid,
    input wire logic [7:0] i_read_data,
    output host_byte_t o_cmd,
    output logic [7:0] o_power_ctl,
    output logic o_wake_access
);
    initial begin
        o_cmd = '0;
        o_power_ctl = 8'h00;
        o_wake_access = 1'b0;
    end

    task automatic send(input logic [7:0] b);
        o_cmd = '{valid: 1'b1, data: b};
        @(posedge i_clock);
        #1;
        o_cmd = '0;
        @(posedge i_clock);
        #1;
    endtask

    task automatic set_timeout(input logic [7:0] n);
        send(CMD_UNLOCK);
        send(CMD_SET_TIMEOUT);
        send(n);
        send(CMD_LOCK);
    endtask

    task automatic write_outctl(input logic [7:0] d);
        send(CMD_WRITE_OUTCTL);
        send(d & 8'hf7);
    endtask

    // The data port is only trusted in the cycle the answer is flagged.
    task automatic read_outctl(output logic [7:0] d);
        d = 'x;
        send(CMD_READ_OUTCTL);
        repeat (8) begin
            if (i_read_valid === 1'b1) d = i_read_data;
            @(posedge i_clock);
            #1;
        end
    endtask

    task automatic set_levels(input logic [1:0] v);
        o_power_ctl[1:0] = v;
    endtask

    task automatic request(input logic partial);
        o_power_ctl[PWR_PARTIAL_BIT] = partial;
        @(posedge i_clock);
        #1;
        o_power_ctl[PWR_REQ_BIT] = 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        o_power_ctl[PWR_REQ_BIT] = 1'b0;
    endtask

    task automatic wake();
        o_wake_access = 1'b1;
        @(posedge i_clock);
        #1;
        o_wake_access = 1'b0;
    endtask
endmodule

// file: testbench/power_properties.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module power_properties
    import sleep_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_soft_reset,
    input wire host_byte_t i_cmd,
    input wire logic [7:0] o_read_data,
    input wire logic o_read_valid,
    input wire logic [7:0] i_power_ctl,
    input wire logic i_wake_access,
    input wire logic i_busy,
    input wire power_state_t o_power_state,
    input wire logic o_activity_owned,
    input wire logic o_aux_output_zero,
    input wire logic o_aux_output_one
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    chk_reset_quiet: assert property ($rose(i_rst_b) |->
        o_power_state == PWR_ON && !o_read_valid) else $error("not on");
    chk_read_answer: assert property (o_read_valid |->
        $past(i_cmd.valid, 2) && $past(i_cmd.data, 2) == CMD_READ_OUTCTL)
        else $error("read without command");
    chk_read_pulse: assert property (o_read_valid |=> !o_read_valid)
        else $error("read valid too long");
    chk_read_hold: assert property (!o_read_valid |-> $stable(o_read_data))
        else $error("read data moved");
    chk_access_wakes: assert property (
        i_wake_access && o_power_state != PWR_ON |->
        ##[1:6] o_power_state == PWR_ON) else $error("no wake");
    chk_soft_wakes: assert property (
        i_soft_reset |-> ##[1:6] o_power_state == PWR_ON)
        else $error("no soft wake");
    chk_req_partial: assert property ($rose(i_power_ctl[PWR_REQ_BIT]) &&
        i_power_ctl[PWR_PARTIAL_BIT] && o_power_state == PWR_ON |->
        ##[2:10] o_power_state == PWR_PARTIAL) else $error("no partial");
    chk_req_full: assert property ($rose(i_power_ctl[PWR_REQ_BIT]) &&
        !i_power_ctl[PWR_PARTIAL_BIT] && o_power_state == PWR_ON |->
        ##[2:10] o_power_state == PWR_FULL) else $error("no full");
    chk_busy_holds: assert property ((i_busy && o_power_state == PWR_ON
        && !i_power_ctl[PWR_REQ_BIT])[*8] |=> o_power_state == PWR_ON)
        else $error("slept while busy");
    chk_partial_normal: assert property ((o_power_state == PWR_PARTIAL
        && $stable(i_power_ctl))[*3] |->
        o_aux_output_zero == i_power_ctl[PWR_OUT0_BIT] &&
        o_aux_output_one == i_power_ctl[PWR_OUT1_BIT])
        else $error("outputs not normal");

    cover property (o_read_valid);
    cover property (o_power_state == PWR_FULL);
    cover property (o_power_state == PWR_PARTIAL && o_activity_owned);
endmodule

bind self_timed_power power_properties u_props (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_soft_reset(i_soft_reset),
    .i_cmd(i_cmd), .o_read_data(o_read_data), .o_read_valid(o_read_valid),
    .i_power_ctl(i_power_ctl), .i_wake_access(i_wake_access),
    .i_busy(i_busy), .o_power_state(o_power_state),
    .o_activity_owned(o_activity_owned),
    .o_aux_output_zero(o_aux_output_zero),
    .o_aux_output_one(o_aux_output_one)
);

// file: testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top import sleep_pkg::*;;
    localparam int IDLE = 20;
    localparam int DLY = 4;
    logic i_clock;
    logic i_rst_b;
    logic i_soft_reset;
    logic i_busy;
    host_byte_t cmd;
    logic [7:0] power_ctl;
    logic [7:0] read_data;
    logic read_valid;
    logic wake_access;
    logic owned;
    logic out0;
    logic out1;
    power_state_t state;
    int mismatches = 0;
    int total_checks = 0;

    self_timed_power #(.IDLE_CYCLES(IDLE), .DELAY_CYCLES(DLY)) u_dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_soft_reset(i_soft_reset),
        .i_cmd(cmd), .o_read_data(read_data), .o_read_valid(read_valid),
        .i_power_ctl(power_ctl), .i_wake_access(wake_access),
        .i_busy(i_busy), .o_power_state(state), .o_activity_owned(owned),
        .o_aux_output_zero(out0), .o_aux_output_one(out1)
    );

    host_model u_host (
        .i_clock(i_clock), .i_read_valid(read_valid),
        .i_read_data(read_data), .o_cmd(cmd), .o_power_ctl(power_ctl),
        .o_wake_access(wake_access)
    );

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic wait_state(input power_state_t s);
        for (int i = 0; i < 100 && state !== s; i++) @(posedge i_clock);
        #1;
        check("state", {6'h0, s}, {6'h0, state});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_register();
        logic [7:0] d;
        u_host.read_outctl(d);
        check("reset outctl", OUTCTL_RESET, d);
        u_host.write_outctl(8'hf3);
        u_host.read_outctl(d);
        check("outctl", 8'hf3, d);
        i_soft_reset = 1'b1;
        step(1);
        i_soft_reset = 1'b0;
        step(2);
        u_host.read_outctl(d);
        check("outctl soft", 8'hf3, d);
    endtask

    task automatic t_full(input logic [7:0] ctl, input logic inv,
                          input logic late);
        u_host.write_outctl(ctl);
        u_host.set_levels(2'b01);
        step(4);
        check("outs on", 8'h01, {6'h0, out1, out0});
        u_host.request(1'b0);
        wait_state(PWR_FULL);
        step(3);
        check("outs full", inv ? 8'h02 : 8'h01, {6'h0, out1, out0});
        u_host.wake();
        wait_state(PWR_ON);
        step(2);
        check("outs wake", late ? 8'h02 : 8'h01, {6'h0, out1, out0});
        step(40);
        check("outs late", 8'h01, {6'h0, out1, out0});
    endtask

    task automatic t_partial();
        u_host.set_levels(2'b10);
        u_host.request(1'b1);
        wait_state(PWR_PARTIAL);
        step(3);
        check("outs partial", 8'h02, {6'h0, out1, out0});
        u_host.wake();
        wait_state(PWR_ON);
    endtask

    task automatic t_timer();
        u_host.set_timeout(8'h01);
        step(2);
        check("owned", 8'h01, {7'h0, owned});
        i_busy = 1'b1;
        step(IDLE * 3);
        check("busy", {6'h0, PWR_ON}, {6'h0, state});
        i_busy = 1'b0;
        wait_state(PWR_PARTIAL);
        u_host.wake();
        wait_state(PWR_ON);
        u_host.request(1'b0);
        wait_state(PWR_FULL);
        u_host.wake();
        wait_state(PWR_ON);
        u_host.set_timeout(8'h00);
        step(2);
        check("owned off", 8'h00, {7'h0, owned});
        step(IDLE * 3);
        check("disabled", {6'h0, PWR_ON}, {6'h0, state});
    endtask

    initial begin
        i_rst_b = 1'b0;
        i_soft_reset = 1'b0;
        i_busy = 1'b0;
        repeat (4) @(posedge i_clock);
        #1;
        i_rst_b = 1'b1;
        step(1);
        t_register();
        t_full(8'h00, 1'b0, 1'b0);
        t_full(8'h50, 1'b1, 1'b0);
        t_full(8'hf3, 1'b1, 1'b1);
        t_partial();
        t_timer();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        mismatches++;
        finish_test();
    end
endmodule
